// *** hdl/apc_proc_cfg.sv ***
`timescale 1ns/100ps
module apc_proc_cfg
(
	input  wire logic                                   i_clk_sys,
	input  wire logic                                   i_rst_b,
	input  wire logic                                   i_reg_wr,
	input  wire logic                                   i_reg_rd,
	input  wire logic [7:0]                             i_reg_addr,
	input  wire logic [7:0]                             i_reg_wdata,
	output logic      [7:0]                             o_reg_rdata,
	input  wire logic                                   i_adc_powered,
	input  wire logic                                   i_mod_tick,
	input  wire logic                                   i_ch4_mod_bit,
	output logic                                        o_ch4_mod_bit,
	input  wire logic                                   i_sample_tick,
	input  wire logic [apc_pkg::SAMPLE_W-1:0]           i_ch1_sample,
	input  wire logic [apc_pkg::SAMPLE_W-1:0]           i_ch2_sample,
	output logic      [apc_pkg::SAMPLE_W-1:0]           o_ch1_out_sample,
	input  wire logic [apc_pkg::NUM_CH-1:0][7:0]        i_channel_volume_code,
	input  wire logic [apc_pkg::NUM_CH-1:0]             i_channel_range_enhance_enable,
	input  wire logic [apc_pkg::NUM_CH-1:0]             i_ch_gain_above_0db,
	output logic      [apc_pkg::NUM_CH-1:0][7:0]        o_ch_volume_applied,
	output logic      [apc_pkg::NUM_CH-1:0]             o_ch_mute,
	output apc_pkg::apc_lvl_t [apc_pkg::NUM_CH-1:0]     o_ch_level_mode,
	output logic      [apc_pkg::NUM_CH-1:0]             o_ch_clip_guard_on,
	output logic                                        o_enhanced_level_algorithms,
	output apc_pkg::apc_decim_t                         o_decimator_response_select,
	output apc_pkg::apc_hp_t                            o_highpass_select,
	output logic                                        o_highpass_custom,
	output logic      [2:0]                             o_biquad_enable
);

	logic [7:0] trim_q;
	logic [7:0] cfg_a_q;
	logic [7:0] cfg_b_q;
	logic [7:0] rdata_q;

	logic       hit_trim;
	logic       hit_a;
	logic       hit_b;
	logic [7:0] rd_mux;

	logic       volume_lock;
	logic       volume_frozen;
	logic       shared_volume;
	logic       ramp_bypass;
	logic       loop_sel;
	logic       comp_en;
	logic       clip_guard;
	logic [1:0] biq_count;

	// Register decode and read mux
	assign hit_trim = (i_reg_addr == apc_pkg::ADDR_PHASE_TRIM);
	assign hit_a    = (i_reg_addr == apc_pkg::ADDR_PROC_A);
	assign hit_b    = (i_reg_addr == apc_pkg::ADDR_PROC_B);

	always_comb
	begin
		if (hit_trim)
			rd_mux = trim_q;
		else if (hit_a)
			rd_mux = cfg_a_q;
		else if (hit_b)
			rd_mux = cfg_b_q;
		else
			rd_mux = apc_pkg::RD_UNMAPPED;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			trim_q  <= apc_pkg::RST_PHASE_TRIM;
			cfg_a_q <= apc_pkg::RST_PROC_A;
			cfg_b_q <= apc_pkg::RST_PROC_B;
		end
		else if (i_reg_wr)
		begin
			if (hit_trim)
				trim_q <= i_reg_wdata;
			if (hit_a)
				cfg_a_q <= i_reg_wdata;
			if (hit_b)
				cfg_b_q <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			rdata_q <= apc_pkg::RD_UNMAPPED;
		else if (i_reg_rd)
			rdata_q <= rd_mux;
	end

	assign o_reg_rdata = rdata_q;

	// Field extraction
	assign volume_lock   = cfg_a_q[apc_pkg::A_VOL_LOCK];
	assign volume_frozen = volume_lock && i_adc_powered;
	assign shared_volume = cfg_b_q[apc_pkg::B_SHARED_VOL];
	assign ramp_bypass   = cfg_b_q[apc_pkg::B_RAMP_BYP];
	assign loop_sel      = cfg_b_q[apc_pkg::B_LOOP_SEL];
	assign comp_en       = cfg_b_q[apc_pkg::B_COMP_EN];
	assign clip_guard    = cfg_b_q[apc_pkg::B_CLIP_GUARD];
	assign biq_count     = cfg_b_q[apc_pkg::B_BIQ_HI:apc_pkg::B_BIQ_LO];

	// Channel four phase trim
	apc_phase_delay u_phase_delay
	(
		.i_clk_sys  (i_clk_sys),
		.i_rst_b    (i_rst_b),
		.i_mod_tick (i_mod_tick),
		.i_mod_bit  (i_ch4_mod_bit),
		.i_trim     (trim_q),
		.o_mod_bit  (o_ch4_mod_bit)
	);

	// Pair summing
	logic signed [apc_pkg::SAMPLE_W:0]   pair_sum;
	logic        [apc_pkg::SAMPLE_W-1:0] pair_avg;
	logic        [apc_pkg::SAMPLE_W-1:0] ch1_out_d;
	logic        [apc_pkg::SAMPLE_W-1:0] ch1_out_q;

	assign pair_sum  = $signed({i_ch1_sample[apc_pkg::SAMPLE_W-1], i_ch1_sample})
	                 + $signed({i_ch2_sample[apc_pkg::SAMPLE_W-1], i_ch2_sample});
	assign pair_avg  = pair_sum[apc_pkg::SAMPLE_W:1];
	assign ch1_out_d = (cfg_a_q[apc_pkg::A_SUM_HI:apc_pkg::A_SUM_LO] == apc_pkg::APC_SUM_PAIR)
	                 ? pair_avg : i_ch1_sample;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			ch1_out_q <= '0;
		else if (i_sample_tick)
			ch1_out_q <= ch1_out_d;
	end

	assign o_ch1_out_sample = ch1_out_q;

	// Static selections
	logic                enh_q;
	apc_pkg::apc_decim_t decim_q;
	apc_pkg::apc_hp_t    hp_q;
	logic                hp_custom_q;
	logic [2:0]          biq_en_d;
	logic [2:0]          biq_en_q;

	assign biq_en_d = (biq_count == 2'b00) ? 3'h0 :
	                  (biq_count == 2'b01) ? 3'h1 :
	                  (biq_count == 2'b10) ? 3'h3 : 3'h7;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			enh_q       <= 1'b0;
			decim_q     <= apc_pkg::APC_DECIM_LINEAR;
			hp_q        <= apc_pkg::APC_HP_F_00025;
			hp_custom_q <= 1'b0;
			biq_en_q    <= 3'h3;
		end
		else
		begin
			enh_q       <= cfg_a_q[apc_pkg::A_ENH_ALGO];
			decim_q     <= apc_pkg::apc_decim_t'(cfg_a_q[apc_pkg::A_DECIM_HI:apc_pkg::A_DECIM_LO]);
			hp_q        <= apc_pkg::apc_hp_t'(cfg_a_q[apc_pkg::A_HP_HI:apc_pkg::A_HP_LO]);
			hp_custom_q <= (cfg_a_q[apc_pkg::A_HP_HI:apc_pkg::A_HP_LO] == apc_pkg::APC_HP_CUSTOM);
			biq_en_q    <= biq_en_d;
		end
	end

	assign o_enhanced_level_algorithms = enh_q;
	assign o_decimator_response_select = decim_q;
	assign o_highpass_select           = hp_q;
	assign o_highpass_custom           = hp_custom_q;
	assign o_biquad_enable             = biq_en_q;

	// Per-channel volume, level mode and clip guard
	genvar c;
	generate
		for (c = 0; c < apc_pkg::NUM_CH; c++)
		begin : g_ch
			logic [7:0]        target;
			logic [7:0]        accepted_q;
			logic [7:0]        cur_q;
			logic [7:0]        cur_d;
			logic              mute_q;
			apc_pkg::apc_lvl_t mode_d;
			apc_pkg::apc_lvl_t mode_q;
			logic              clip_q;

			assign target = shared_volume ? i_channel_volume_code[0]
			                              : i_channel_volume_code[c];

			assign cur_d = ramp_bypass               ? accepted_q :
			               (cur_q < accepted_q)      ? cur_q + apc_pkg::VOL_STEP :
			               (cur_q > accepted_q)      ? cur_q - apc_pkg::VOL_STEP :
			               cur_q;

			assign mode_d = comp_en ? apc_pkg::APC_LVL_COMPRESS :
			                !i_channel_range_enhance_enable[c] ? apc_pkg::APC_LVL_NONE :
			                loop_sel ? apc_pkg::APC_LVL_GAINLOOP
			                         : apc_pkg::APC_LVL_ENHANCER;

			always_ff @(posedge i_clk_sys)
			begin
				if (!i_rst_b)
				begin
					accepted_q <= apc_pkg::VOL_MUTE_CODE;
					cur_q      <= apc_pkg::VOL_MUTE_CODE;
					mute_q     <= 1'b1;
					mode_q     <= apc_pkg::APC_LVL_NONE;
					clip_q     <= 1'b0;
				end
				else
				begin
					if (!volume_frozen)
						accepted_q <= target;
					if (i_sample_tick)
					begin
						cur_q  <= cur_d;
						mute_q <= (cur_d == apc_pkg::VOL_MUTE_CODE);
					end
					mode_q <= mode_d;
					clip_q <= clip_guard && i_ch_gain_above_0db[c]
					          && (mode_d != apc_pkg::APC_LVL_NONE);
				end
			end

			assign o_ch_volume_applied[c] = cur_q;
			assign o_ch_mute[c]           = mute_q;
			assign o_ch_level_mode[c]     = mode_q;
			assign o_ch_clip_guard_on[c]  = clip_q;
		end
	endgenerate

endmodule // apc_proc_cfg

// *** hdl/apc_pkg.sv ***
package apc_pkg;

	localparam int unsigned NUM_CH     = 4;
	localparam int unsigned SAMPLE_W   = 16;
	localparam int unsigned TRIM_DEPTH = 256;

	localparam logic [7:0] ADDR_PHASE_TRIM = 8'h4F;
	localparam logic [7:0] ADDR_PROC_A     = 8'h6B;
	localparam logic [7:0] ADDR_PROC_B     = 8'h6C;

	localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
	localparam logic [7:0] RST_PROC_A     = 8'h01;
	localparam logic [7:0] RST_PROC_B     = 8'h40;
	localparam logic [7:0] RD_UNMAPPED    = 8'h00;

	// Processing config A fields
	localparam int unsigned A_VOL_LOCK  = 7;
	localparam int unsigned A_ENH_ALGO  = 6;
	localparam int unsigned A_DECIM_HI  = 5;
	localparam int unsigned A_DECIM_LO  = 4;
	localparam int unsigned A_SUM_HI    = 3;
	localparam int unsigned A_SUM_LO    = 2;
	localparam int unsigned A_HP_HI     = 1;
	localparam int unsigned A_HP_LO     = 0;

	// Processing config B fields
	localparam int unsigned B_SHARED_VOL = 7;
	localparam int unsigned B_BIQ_HI     = 6;
	localparam int unsigned B_BIQ_LO     = 5;
	localparam int unsigned B_RAMP_BYP   = 4;
	localparam int unsigned B_LOOP_SEL   = 3;
	localparam int unsigned B_COMP_EN    = 1;
	localparam int unsigned B_CLIP_GUARD = 0;

	localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
	localparam logic [7:0] VOL_STEP      = 8'h01;

	typedef enum logic [1:0] {
		APC_DECIM_LINEAR    = 2'b00,
		APC_DECIM_LOW_LAT   = 2'b01,
		APC_DECIM_ULTRA_LOW = 2'b10
	} apc_decim_t;

	typedef enum logic [1:0] {
		APC_SUM_OFF  = 2'b00,
		APC_SUM_PAIR = 2'b01
	} apc_sum_t;

	typedef enum logic [1:0] {
		APC_HP_CUSTOM   = 2'b00,
		APC_HP_F_00025  = 2'b01,
		APC_HP_F_002    = 2'b10,
		APC_HP_F_008    = 2'b11
	} apc_hp_t;

	typedef enum logic [1:0] {
		APC_LVL_NONE     = 2'b00,
		APC_LVL_ENHANCER = 2'b01,
		APC_LVL_GAINLOOP = 2'b10,
		APC_LVL_COMPRESS = 2'b11
	} apc_lvl_t;

endpackage

// *** hdl/apc_phase_delay.sv ***
`timescale 1ns/100ps
module apc_phase_delay
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic       i_mod_tick,
	input  wire logic       i_mod_bit,
	input  wire logic [7:0] i_trim,
	output logic            o_mod_bit
);

	localparam int unsigned TRIM_LAST = apc_pkg::TRIM_DEPTH - 1;

	logic [TRIM_LAST:0] mem_q;
	logic [7:0]         wr_ptr_q;
	logic [7:0]         rd_ptr;
	logic               delayed_bit;
	logic               out_d;
	logic               out_q;

	assign rd_ptr      = wr_ptr_q - i_trim;
	assign delayed_bit = mem_q[rd_ptr];
	assign out_d       = (i_trim == 8'h00) ? i_mod_bit : delayed_bit;

	genvar g;
	generate
		for (g = 0; g < apc_pkg::TRIM_DEPTH; g++)
		begin : g_cell
			always_ff @(posedge i_clk_sys)
			begin
				if (!i_rst_b)
					mem_q[g] <= 1'b0;
				else if (i_mod_tick && (wr_ptr_q == 8'(g)))
					mem_q[g] <= i_mod_bit;
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			wr_ptr_q <= 8'h00;
			out_q    <= 1'b0;
		end
		else if (i_mod_tick)
		begin
			wr_ptr_q <= wr_ptr_q + 8'h01;
			out_q    <= out_d;
		end
	end

	assign o_mod_bit = out_q;

endmodule // apc_phase_delay

// *** verification/apc_proc_cfg_assertions.sv ***
`timescale 1ns/100ps
module apc_proc_cfg_checker
(
	input wire logic                 i_clk_sys,
	input wire logic                 i_rst_b,
	input wire logic                 i_reg_wr,
	input wire logic                 i_reg_rd,
	input wire logic [7:0]           i_reg_addr,
	input wire logic [7:0]           i_reg_wdata,
	input wire logic [7:0]           o_reg_rdata,
	input wire logic [3:0]           i_ch_gain_above_0db,
	input apc_pkg::apc_lvl_t [3:0]   o_ch_level_mode,
	input wire logic [3:0]           o_ch_clip_guard_on,
	input wire logic                 o_enhanced_level_algorithms,
	input apc_pkg::apc_decim_t       o_decimator_response_select,
	input wire logic                 o_highpass_custom,
	input wire logic [2:0]           o_biquad_enable
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	wire ra = i_reg_addr == apc_pkg::ADDR_PROC_A;
	wire rb = i_reg_addr == apc_pkg::ADDR_PROC_B;
	wire rt = i_reg_addr == apc_pkg::ADDR_PHASE_TRIM;
	wire wa = i_reg_wr && ra;
	wire wb = i_reg_wr && rb;
	property p_decim;
		wa |-> ##2 o_decimator_response_select == $past(i_reg_wdata[5:4], 2);
	endproperty
	a_decim: assert property (p_decim) else $error("decimator select wrong");
	property p_custom;
		wa |-> ##2 o_highpass_custom == ($past(i_reg_wdata[1:0], 2) == 2'h0);
	endproperty
	a_custom: assert property (p_custom) else $error("highpass custom wrong");
	property p_enh;
		wa |-> ##2 o_enhanced_level_algorithms == $past(i_reg_wdata[6], 2);
	endproperty
	a_enh: assert property (p_enh) else $error("enhanced bit wrong");
	property p_biq;
		wb |-> ##2 o_biquad_enable == (3'h7 >> (2'h3 - $past(i_reg_wdata[6:5], 2)));
	endproperty
	a_biq: assert property (p_biq) else $error("biquad enables wrong");
	property p_hold;
		!i_reg_rd |=> $stable(o_reg_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap;
		i_reg_rd && !(ra || rb || rt) |=> o_reg_rdata == apc_pkg::RD_UNMAPPED;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_rdback;
		wa ##1 (i_reg_rd && ra) |=> o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_rdback: assert property (p_rdback) else $error("readback wrong");
	property p_clip;
		o_ch_clip_guard_on[0] |-> $past(i_ch_gain_above_0db[0])
			&& o_ch_level_mode[0] != apc_pkg::APC_LVL_NONE;
	endproperty
	a_clip: assert property (p_clip) else $error("clip guard without cause");
endmodule // apc_proc_cfg_checker
bind apc_proc_cfg apc_proc_cfg_checker apc_proc_cfg_checker_i (.*);

// *** verification/tb_apc_proc_cfg.sv ***
`timescale 1ns/100ps
module tb_apc_proc_cfg;
	logic                      clk, rst_b, wr, rd, pw, mt, mb, st, enh, cu, ob;
	logic [7:0]                ad, wd, rdat;
	logic [15:0]               s1, s2, so;
	logic [3:0]                en, gn, mu, cg;
	logic [3:0][7:0]           vc, va;
	logic [2:0]                bq;
	apc_pkg::apc_lvl_t [3:0]   lm;
	apc_pkg::apc_decim_t       dec;
	apc_pkg::apc_hp_t          hp;
	int                        err_count, comparisons;
	localparam logic [7:0] A = apc_pkg::ADDR_PROC_A;
	localparam logic [7:0] B = apc_pkg::ADDR_PROC_B;
	apc_proc_cfg apc_proc_cfg_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat),
		.i_adc_powered(pw), .i_mod_tick(mt), .i_ch4_mod_bit(mb), .o_ch4_mod_bit(ob),
		.i_sample_tick(st), .i_ch1_sample(s1), .i_ch2_sample(s2), .o_ch1_out_sample(so),
		.i_channel_volume_code(vc), .i_channel_range_enhance_enable(en),
		.i_ch_gain_above_0db(gn), .o_ch_volume_applied(va), .o_ch_mute(mu),
		.o_ch_level_mode(lm), .o_ch_clip_guard_on(cg), .o_enhanced_level_algorithms(enh),
		.o_decimator_response_select(dec), .o_highpass_select(hp),
		.o_highpass_custom(cu), .o_biquad_enable(bq));
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task summarize;
		$display("checks %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'h1;
		ad <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task r(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'h1;
		ad <= a;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		chk("rdata", rdat, e);
	endtask
	task ts;
		@(posedge clk);
		st <= 1'h1;
		@(posedge clk);
		st <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task tm(input logic b);
		@(posedge clk);
		mt <= 1'h1;
		mb <= b;
		@(posedge clk);
		mt <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task t_reset;
		r(apc_pkg::ADDR_PHASE_TRIM, apc_pkg::RST_PHASE_TRIM);
		r(A, apc_pkg::RST_PROC_A);
		r(B, apc_pkg::RST_PROC_B);
		r(8'h50, apc_pkg::RD_UNMAPPED);
		chk("hp", hp, 2'h1);
		chk("biq", bq, 3'h3);
	endtask
	task t_trim;
		logic [7:0] p;
		p = 8'hB2;
		w(apc_pkg::ADDR_PHASE_TRIM, 8'h03);
		for (int k = 0; k < 8; k++)
		begin
			tm(p[k]);
			chk("ch4", ob, (k < 3) ? 1'h0 : p[k-3]);
		end
		w(apc_pkg::ADDR_PHASE_TRIM, 8'h00);
		tm(1'h1);
		chk("ch4", ob, 1'h1);
		tm(1'h0);
		chk("ch4", ob, 1'h0);
	endtask
	task t_cfg;
		logic [7:0] d;
		logic [1:0] c;
		logic [2:0] q;
		for (int i = 0; i < 4; i++)
		begin
			c = (i == 3) ? 2'h0 : i[1:0];
			d = {1'h0, i[0], c, 2'h0, i[1:0]};
			w(A, d);
			chk("dec", dec, c);
			chk("hp", hp, i[1:0]);
			chk("cust", cu, i == 0);
			chk("enh", enh, i[0]);
			r(A, d);
			q = (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : (i == 2) ? 3'h3 : 3'h7;
			w(B, {1'h0, i[1:0], 5'h0});
			chk("biq", bq, q);
		end
		@(posedge clk);
		wr <= 1'h1;
		ad <= A;
		wd <= 8'h21;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk("b2b", rdat, 8'h21);
	endtask
	task t_sum;
		w(A, 8'h05);
		@(posedge clk);
		s1 <= 16'h0064;
		s2 <= 16'hFFCE;
		ts;
		chk("sum", so, 16'h0019);
		@(posedge clk);
		s1 <= 16'hFF9B;
		s2 <= 16'h0000;
		ts;
		chk("sum", so, 16'hFFCD);
		w(A, 8'h01);
		ts;
		chk("nosum", so, 16'hFF9B);
	endtask
	task t_vol;
		w(B, 8'h90);
		ts;
		chk("gang", va[2], 8'h20);
		w(B, 8'h10);
		ts;
		chk("own", va[2], 8'h50);
		w(A, 8'h81);
		@(posedge clk);
		vc[0] <= 8'h30;
		ts;
		chk("lock", va[0], 8'h20);
		w(A, 8'h01);
		ts;
		chk("unlock", va[0], 8'h30);
		w(B, 8'h00);
		@(posedge clk);
		vc[0] <= 8'h33;
		ts;
		chk("ramp", va[0], 8'h31);
		w(B, 8'h10);
		@(posedge clk);
		vc[0] <= 8'h00;
		ts;
		chk("mute", mu[0], 1'h1);
		w(A, 8'h81);
		@(posedge clk);
		pw <= 1'h0;
		vc[0] <= 8'h44;
		ts;
		chk("unpowered", va[0], 8'h44);
		@(posedge clk);
		pw <= 1'h1;
		w(A, 8'h01);
	endtask
	task t_mode;
		@(posedge clk);
		en <= 4'h1;
		gn <= 4'h1;
		w(B, 8'h01);
		chk("enhancer", lm[0], apc_pkg::APC_LVL_ENHANCER);
		chk("clip", cg[0], 1'h1);
		chk("off", lm[1], apc_pkg::APC_LVL_NONE);
		w(B, 8'h09);
		chk("gainloop", lm[0], apc_pkg::APC_LVL_GAINLOOP);
		w(B, 8'h03);
		chk("comp", lm[0], apc_pkg::APC_LVL_COMPRESS);
		@(posedge clk);
		gn <= 4'h0;
		w(B, 8'h03);
		chk("noclip", cg[0], 1'h0);
	endtask
	task t_rerst;
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		t_reset;
		chk("mute_rst", mu, 4'hF);
	endtask
	initial
	begin
		err_count = 0;
		comparisons = 0;
		{rst_b, wr, rd, mt, mb, st, ad, wd, s1, s2, en, gn} = '0;
		pw = 1'h1;
		vc = {8'h00, 8'h50, 8'h00, 8'h20};
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		t_reset;
		t_trim;
		t_cfg;
		t_sum;
		t_vol;
		t_mode;
		t_rerst;
		summarize;
	end
	initial
	begin
		#100000;
		err_count++;
		summarize;
	end
endmodule // tb_apc_proc_cfg
